// File: core/flash_seq_pkg.sv
package flash_seq_pkg;

  // ==========================================================
  // Clock and timing clock window
  // ==========================================================
  localparam int CLK_HZ = 10_000_000;      // Bus clock rate
  localparam int FLASH_TIMING_CLOCK_MIN_HZ = 150_000;    // Slowest timing clock
  localparam int FLASH_TIMING_CLOCK_MAX_HZ = 200_000;    // Fastest timing clock
  // Fewest bus cycles per timing tick, rounded up
  localparam int TICK_CYC_MIN = (CLK_HZ + FLASH_TIMING_CLOCK_MAX_HZ - 1) / FLASH_TIMING_CLOCK_MAX_HZ;
  // Most bus cycles per timing tick, rounded down
  localparam int TICK_CYC_MAX = CLK_HZ / FLASH_TIMING_CLOCK_MIN_HZ;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int ADDR_W = 16;              // Array word address
  localparam int DATA_W = 16;              // Array word data
  localparam int ROW_LSB = 5;              // Lowest row address bit
  localparam int TMR_W = 16;               // Sequencer tick timer

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_DIV = 8'h00;  // Divider register
  localparam logic [7:0] OFS_CMD = 8'h04;  // Command holding
  localparam logic [7:0] OFS_ADDR = 8'h08; // Address holding
  localparam logic [7:0] OFS_DATA = 8'h0c; // Data holding
  localparam logic [7:0] OFS_STAT = 8'h10; // Status register
  localparam logic [7:0] OFS_MASK = 8'h14; // Interrupt enables

  // ==========================================================
  // Status fields
  // ==========================================================
  localparam int EV_EMPTY = 0;             // Buffer emptied event
  localparam int EV_DONE = 1;              // Command complete event
  localparam int EV_REFUSED = 2;           // Command refused event
  localparam int ST_BUF_EMPTY = 4;         // Buffer empty level
  localparam int ST_BUSY = 5;              // Sequencer busy level
  localparam int ST_BLANK = 6;             // Last verify result
  localparam int ST_DIV_OK = 7;            // Divider in window

  // ==========================================================
  // Commands
  // ==========================================================
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] CMD_VERIFY = 8'h05;

  // ==========================================================
  // Algorithm lengths in timing clock ticks, and reset values
  // ==========================================================
  localparam logic [TMR_W-1:0] HV_RAMP_TICKS = 16'h0004;
  localparam logic [TMR_W-1:0] PROG_TICKS = 16'h0008;
  localparam logic [TMR_W-1:0] ERASE_TICKS = 16'h0020;
  localparam logic [TMR_W-1:0] VERIFY_TICKS = 16'h0002;
  localparam logic [TMR_W-1:0] HV_FALL_TICKS = 16'h0002;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_ramp = 4'b0010,
    st_run = 4'b0100,
    st_fall = 4'b1000
  } seq_state_t;

  // Request carried to the array
  typedef struct packed {
    logic [7:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic hv_on;
    logic start;
  } array_req_t;

endpackage

// File: core/flash_command_sequencer.sv
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// [R01] Timed algorithms run from divided timing clock
// [R02] Holding registers form a two-stage buffer
// [R03] Same-row program chain keeps high voltage on
// [R04] Empty and done flags raise enabled interrupts
// [R05] Software sets divider for 150-200 kHz first
// [R06] Software divider choice accounts for bus clock
// [R07] No launch before divider written since reset
module flash_command_sequencer
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt
  output logic irq,
  // Flash array side
  output array_req_t array_req,
  input wire logic array_blank
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    seq_state_t st;               // Sequencer state
    logic [7:0] div;              // Timing clock divider
    logic div_ok;                 // Divider written since reset
    logic [7:0] tcnt;             // Divider counter
    logic hb_valid;               // Holding stage full
    logic [7:0] hb_cmd;           // Holding command
    logic [ADDR_W-1:0] hb_addr;   // Holding address
    logic [DATA_W-1:0] hb_data;   // Holding data
    logic [7:0] act_cmd;          // Executing command
    logic [ADDR_W-1:0] act_addr;  // Executing address
    logic [DATA_W-1:0] act_data;  // Executing data
    logic [TMR_W-1:0] timer;      // Ticks left in phase
    logic start;                  // Array start pulse
    logic blank;                  // Last verify result
    logic [2:0] flags;            // Sticky events
    logic [2:0] mask;             // Interrupt enables
    logic ack;                    // Bus acknowledge
    logic [31:0] rdata;           // Read data
  } state_t;

  state_t s;
  state_t next_s;

  // Helper terms
  logic tick;                     // Timing clock tick
  logic div_in_range;             // Divider inside window
  logic [31:0] wmask;             // Byte lane mask
  logic [31:0] wval_div;          // Merged divider write
  logic wr;                       // Write taken this edge
  logic wr_cmd;                   // Command write taken
  logic cmd_legal;                // Written command known
  logic chain;                    // Same-row program follows
  logic [2:0] ev;                 // Events this cycle

  // Byte lanes to bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{sel_i[i]}};
    end
  end

  // Decode of write and divider checks
  always_comb begin
    wr = cyc_i && stb_i && we_i && s.ack;
    wr_cmd = wr && (adr_i == OFS_CMD) && sel_i[0];
    wval_div = ({24'h000000, s.div} & ~wmask) | (dat_i & wmask);
    cmd_legal = (dat_i[7:0] == CMD_PROGRAM) ||
                (dat_i[7:0] == CMD_ERASE) ||
                (dat_i[7:0] == CMD_VERIFY);
    div_in_range = ({24'h000000, s.div} + 32'h1 >= 32'(TICK_CYC_MIN))
                && ({24'h000000, s.div} + 32'h1 <= 32'(TICK_CYC_MAX));
    // Timing clock divided from the bus clock
    tick = s.div_ok && (s.tcnt == s.div); // R01
    chain = (s.act_cmd == CMD_PROGRAM) && s.hb_valid &&
            (s.hb_cmd == CMD_PROGRAM) &&
            (s.hb_addr[ADDR_W-1:ROW_LSB] ==
             s.act_addr[ADDR_W-1:ROW_LSB]);
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_s = s;
    ev = 3'h0;
    next_s.start = 1'b0;
    // Divider counter
    if (tick || !s.div_ok) begin
      next_s.tcnt = 8'h00;
    end else begin
      next_s.tcnt = s.tcnt + 8'h01;
    end
    // Bus acknowledge, one cycle after request
    next_s.ack = cyc_i && stb_i && !s.ack;
    // Read data captured as acknowledge rises
    if (cyc_i && stb_i && !s.ack && !we_i) begin
      unique case (adr_i)
        OFS_DIV: next_s.rdata = {24'h000000, s.div};
        OFS_CMD: next_s.rdata = {24'h000000, s.hb_cmd};
        OFS_ADDR: next_s.rdata = 32'(s.hb_addr);
        OFS_DATA: next_s.rdata = 32'(s.hb_data);
        OFS_STAT: begin
          next_s.rdata = {24'h000000, div_in_range, s.blank,
                          !(s.st == st_idle), !s.hb_valid,
                          1'b0, s.flags};
        end
        OFS_MASK: next_s.rdata = {29'h0, s.mask};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // Register writes
    if (wr && adr_i == OFS_DIV && sel_i[0]) begin
      next_s.div = wval_div[7:0];
      next_s.div_ok = 1'b1;
      next_s.tcnt = 8'h00;
    end
    // Address and data load only into an empty holding stage
    if (wr && adr_i == OFS_ADDR && !s.hb_valid) begin
      next_s.hb_addr = ADDR_W'((32'(s.hb_addr) & ~wmask) |
                               (dat_i & wmask));
    end
    if (wr && adr_i == OFS_DATA && !s.hb_valid) begin
      next_s.hb_data = DATA_W'((32'(s.hb_data) & ~wmask) |
                               (dat_i & wmask));
    end
    if (wr_cmd) begin
      // Refuse while divider unset, buffer full or unknown
      if (!s.div_ok || s.hb_valid || !cmd_legal) begin
        ev[EV_REFUSED] = 1'b1; // R07
      end else begin
        next_s.hb_valid = 1'b1; // R02
        next_s.hb_cmd = dat_i[7:0];
      end
    end
    if (wr && adr_i == OFS_MASK && sel_i[0]) begin
      next_s.mask = dat_i[2:0];
    end
    // Sequencer
    unique case (s.st)
      st_idle: begin
        // Launch only with divider set
        if (s.hb_valid && s.div_ok) begin // R07
          next_s.act_cmd = s.hb_cmd; // R02
          next_s.act_addr = s.hb_addr;
          next_s.act_data = s.hb_data;
          next_s.hb_valid = 1'b0;
          ev[EV_EMPTY] = 1'b1; // R04
          next_s.timer = HV_RAMP_TICKS;
          next_s.st = st_ramp;
        end
      end
      st_ramp: begin
        // High voltage settling
        if (tick) begin // R01
          if (s.timer == '0) begin
            next_s.st = st_run;
            next_s.start = 1'b1;
            if (s.act_cmd == CMD_PROGRAM) begin
              next_s.timer = PROG_TICKS;
            end else if (s.act_cmd == CMD_ERASE) begin
              next_s.timer = ERASE_TICKS;
            end else begin
              next_s.timer = VERIFY_TICKS;
            end
          end else begin
            next_s.timer = s.timer - 16'h0001;
          end
        end
      end
      st_run: begin
        // Algorithm body
        if (tick) begin // R01
          if (s.timer == '0) begin
            ev[EV_DONE] = 1'b1; // R04
            if (s.act_cmd == CMD_VERIFY) begin
              next_s.blank = array_blank;
            end
            if (chain) begin
              // Next word on the same row, voltage stays up
              next_s.act_cmd = s.hb_cmd; // R03
              next_s.act_addr = s.hb_addr;
              next_s.act_data = s.hb_data;
              next_s.hb_valid = 1'b0;
              ev[EV_EMPTY] = 1'b1;
              next_s.timer = PROG_TICKS;
              next_s.start = 1'b1;
            end else begin
              next_s.timer = HV_FALL_TICKS;
              next_s.st = st_fall;
            end
          end else begin
            next_s.timer = s.timer - 16'h0001;
          end
        end
      end
      st_fall: begin
        // High voltage discharge
        if (tick) begin // R01
          if (s.timer == '0) begin
            next_s.st = st_idle;
          end else begin
            next_s.timer = s.timer - 16'h0001;
          end
        end
      end
    endcase
    // Sticky flags, set beats write-one-to-clear
    if (wr && adr_i == OFS_STAT && sel_i[0]) begin
      next_s.flags = (s.flags & ~dat_i[2:0]) | ev; // R04
    end else begin
      next_s.flags = s.flags | ev;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.st <= st_idle;
      s.div <= DIV_RESET;
      s.mask <= MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign irq = |(s.flags & s.mask); // R04
  assign array_req.op = s.act_cmd;
  assign array_req.addr = s.act_addr;
  assign array_req.data = s.act_data;
  assign array_req.hv_on = (s.st == st_ramp) || (s.st == st_run);
  assign array_req.start = s.start;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_paces_fsm: assert property ( // R01
    !tick && s.st != st_idle |=> s.st == $past(s.st))
    else $error("sequencer moved without a timing tick");

  a_full_buffer_refuses: assert property ( // R02
    wr_cmd && s.hb_valid && s.st != st_idle && !(tick && s.timer == '0)
    |=> s.flags[EV_REFUSED] && s.hb_valid)
    else $error("command accepted into full buffer");

  a_row_chain_hv: assert property ( // R03
    s.st == st_run && tick && s.timer == '0 && chain
    |=> s.st == st_run && array_req.hv_on && array_req.start)
    else $error("high voltage dropped in same-row chain");

  a_done_irq: assert property ( // R04
    ev[EV_DONE] && s.mask[EV_DONE] && !(wr && adr_i == OFS_MASK)
    |=> s.flags[EV_DONE] && irq)
    else $error("completion did not raise interrupt");

  a_no_div_no_launch: assert property ( // R07
    !s.div_ok |-> s.st == st_idle && !array_req.start && !s.hb_valid)
    else $error("launch without divider setting");

  a_launch_empties: assert property ( // R02
    s.st == st_idle && s.hb_valid && s.div_ok
    |=> s.st == st_ramp && !s.hb_valid && s.flags[EV_EMPTY])
    else $error("queued command not launched from idle");

  a_start_on_tick: assert property ( // R01
    s.start |-> $past(tick) && s.st == st_run)
    else $error("algorithm body started off a timing tick");

  c_row_chain: cover property (
    s.st == st_run && tick && s.timer == '0 && chain);
  c_verify_done: cover property (
    ev[EV_DONE] && s.act_cmd == CMD_VERIFY);
  c_refused: cover property (ev[EV_REFUSED]);
  c_erase_run: cover property (s.st == st_run && s.act_cmd == CMD_ERASE);
  c_irq_level: cover property (irq);

endmodule

`default_nettype wire

// File: test/flash_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Flash array stand-in: remembers whether the last erase or program body erased
// ============================================================
module flash_array_model
  import flash_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from sequencer
  input wire array_req_t req,
  // Verify answer
  output logic blank
);
  // Erase leaves array blank, program dirties it
  always_ff @(posedge clk) begin
    if (rst) begin
      blank <= 1'b0;
    end else if (req.start) begin
      if (req.op == CMD_ERASE) begin
        blank <= 1'b1;
      end else if (req.op == CMD_PROGRAM) begin
        blank <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/test_flash_command_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the flash command sequencer
// ============================================================
module test_flash_command_sequencer
  import flash_seq_pkg::*;
;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic ack_o, irq, blank, hv_prev = 0;
  logic [3:0] sel = 4'hf;
  array_req_t array_req;
  logic [63:0] notes[$]; // Mask and expected read data
  logic [31:0] seed = 32'h8ef3;
  int err_count = 0, checks_done = 0, starts = 0, falls = 0, hv_cyc = 0;
  logic [7:0] d;
  logic [15:0] w1, w2;

  always #50 clk = ~clk; // 10 MHz bus clock

  flash_command_sequencer flash_command_sequencer_i (.clk(clk), .rst(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq(irq),
    .array_req(array_req), .array_blank(blank));
  flash_array_model flash_array_model_i (.clk(clk), .rst(rst),
    .req(array_req), .blank(blank));

  // Xorshift source for divider and data
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare one value, count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic Wishbone cycle, reads leave a note
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= wd;
    if (!w) notes.push_back({m, e});
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Write and issue helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    wb(1'b1, a, wd, 32'h0, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] a,
    input logic [15:0] wd);
    wr(OFS_ADDR, {16'h0, a});
    wr(OFS_DATA, {16'h0, wd});
    wr(OFS_CMD, {24'h0, op});
  endtask

  // Poll until buffer empty and sequencer idle
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      wb(1'b0, OFS_STAT, 32'h0, 32'h0, 32'h0);
      n++;
    end while ((q[ST_BUSY] !== 1'b0 || q[ST_BUF_EMPTY] !== 1'b1) && n < 2000);
    if (n >= 2000) err_count++;
  endtask

  // Read results are compared against the oldest note
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we === 1'b0 && cyc && notes.size() > 0) begin
      logic [63:0] nt;
      nt = notes.pop_front();
      check(dat_o & nt[63:32], nt[31:0] & nt[63:32]);
    end
  end

  // Count bodies, high-voltage spans and high-voltage cycles
  always @(posedge clk) begin
    if (array_req.start === 1'b1) starts++;
    if (array_req.hv_on === 1'b1) hv_cyc++;
    if (hv_prev && array_req.hv_on !== 1'b1) falls++;
    hv_prev <= (array_req.hv_on === 1'b1);
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and unmapped place
    wb(1'b0, OFS_DIV, 0, 32'hffffffff, {24'h0, DIV_RESET});
    wb(1'b0, OFS_MASK, 0, 32'h7, {29'h0, MASK_RESET});
    wb(1'b0, OFS_STAT, 0, 32'hff, 32'h10);
    wb(1'b0, 8'h18, 0, 32'hffffffff, 32'h0);
    // Command before divider: refused, array untouched
    wr(OFS_MASK, 32'h4);
    cmd(CMD_PROGRAM, 16'h0010, 16'h1234);
    wb(1'b0, OFS_STAT, 0, 32'h27, 32'h4);
    check(irq, 1);
    check(starts, 0);
    wr(OFS_STAT, 32'h4);
    @(posedge clk);
    check(irq, 0);
    // Divider inside the timing window
    d = 8'(TICK_CYC_MIN - 1) +
      8'(xs() % (TICK_CYC_MAX - TICK_CYC_MIN + 1));
    wr(OFS_DIV, {24'h0, d});
    wb(1'b0, OFS_DIV, 0, 32'hff, {24'h0, d});
    wb(1'b0, OFS_STAT, 0, 32'h80, 32'h80);
    // Erase timed by divided clock
    hv_cyc = 0;
    cmd(CMD_ERASE, 16'h0100, 16'h0);
    idle_wait();
    check(array_req.op, {24'h0, CMD_ERASE});
    check(hv_cyc >= 38 * (d + 1) - d - 3 && hv_cyc <= 38 * (d + 1) + d + 3,
      1);
    wb(1'b0, OFS_STAT, 0, 32'h7, 32'h3);
    wr(OFS_MASK, 32'h3);
    @(posedge clk);
    check(irq, 1);
    wr(OFS_STAT, 32'h7);
    @(posedge clk);
    check(irq, 0);
    // Verify after erase reads blank
    cmd(CMD_VERIFY, 16'h0100, 16'h0);
    idle_wait();
    wb(1'b0, OFS_STAT, 0, 32'h40, 32'h40);
    // Same-row chain, third command meets a full buffer
    starts = 0;
    falls = 0;
    w1 = 16'(xs());
    w2 = 16'(xs());
    cmd(CMD_PROGRAM, 16'h0040, w1);
    cmd(CMD_PROGRAM, 16'h0041, w2);
    cmd(CMD_PROGRAM, 16'h0042, 16'h5555);
    wb(1'b0, OFS_STAT, 0, 32'h34, 32'h24);
    idle_wait();
    check(starts, 2);
    check(falls, 1);
    check(array_req.addr, 32'h41);
    check(array_req.data, {16'h0, w2});
    cmd(CMD_VERIFY, 16'h0040, 16'h0);
    idle_wait();
    wb(1'b0, OFS_STAT, 0, 32'h40, 32'h0);
    // Second reset forgets the divider, launches refused again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFS_DIV, 0, 32'hff, {24'h0, DIV_RESET});
    starts = 0;
    cmd(CMD_ERASE, 16'h0200, 16'h0);
    wb(1'b0, OFS_STAT, 0, 32'hf7, 32'h14);
    check(starts, 0);
    check(irq, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
